// ==== src/scs_pkg.sv ====
/*
 * Shared constants and types for the switch control and status registers.
 * Assumes a single 25 MHz core clock; offsets are byte addresses.
 */

package scs_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] SWITCH_STATUS_OFS = 12'h0a0;
	localparam logic [11:0] SWITCH_CONTROL_OFS = 12'h0a4;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int STS_IRQ_B_BIT = 21;
	localparam int STS_IRQ_C_BIT = 22;
	localparam int STS_IRQ_D_BIT = 23;
	localparam int CTL_RESET_BIT = 0;
	localparam int CTL_HOLD_BIT = 1;
	localparam int CTL_UNLOCK_BIT = 2;
	localparam int CTL_RO_DIS_BIT = 3;
	localparam int CTL_LREV_LSB = 4;
	localparam int CTL_ROS_BIT = 8;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic RST_VAL_UNLOCK = 1'h0;
	localparam logic RST_VAL_RO_DIS = 1'h0;
	localparam logic RST_VAL_ROS = 1'h0;
	localparam logic RST_VAL_HOLD = 1'h0;
	localparam logic [31:0] RST_VAL_RDATA = 32'h0000_0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int MIN_RESET_NS = 1000;
	localparam logic [7:0] MIN_RESET_CYC =
		8'((MIN_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SRC_CFG, SRC_SMBUS, SRC_EEPROM} scs_src_t;
	typedef enum {ST_ASSERT, ST_INIT, ST_HALT, ST_RUN} scs_state_t;

endpackage

// ==== src/scs_seq_if.sv ====
/*
 * Carrier between the register bank and the reset sequencer.
 * Assumes both ends share CLOCK and ARST_N of the top module.
 */

`timescale 1ns/1ps
`default_nettype none

interface scs_seq_if;
	logic fund_start;
	logic strap_sample;
	logic running;
	logic eeprom_phase;
	logic core_rst_n;
	logic sw_reset;
	logic hold;

	modport seq
	(
		output fund_start, strap_sample, running, eeprom_phase, core_rst_n,
		input sw_reset, hold
	);
	modport regs
	(
		input fund_start, strap_sample, running, eeprom_phase, core_rst_n,
		output sw_reset, hold
	);
endinterface

`default_nettype wire

// ==== src/scs_rst_seq.sv ====
/*
 * Fundamental reset sequencer: assert, strap capture, eeprom load, halt.
 * Assumes fund_rst_n and eeprom inputs are synchronous to clk.
 */

`timescale 1ns/1ps
`default_nettype none

module scs_rst_seq
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// reset sources and eeprom progress
	input wire logic fund_rst_n,
	input wire logic eeprom_init_en,
	input wire logic eeprom_done,
	// towards the register bank
	scs_seq_if.seq bus
);
	scs_pkg::scs_state_t state;
	scs_pkg::scs_state_t next_state;
	logic [7:0] cnt;
	logic restart;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// hold is looked at only before run, so later writes are inert
	always_comb
	begin
		restart = !fund_rst_n || (bus.sw_reset && state != scs_pkg::ST_ASSERT);
		next_state = state;
		case (state)
			scs_pkg::ST_ASSERT:
				if (cnt == 8'h00 && fund_rst_n)
					next_state = scs_pkg::ST_INIT;
			scs_pkg::ST_INIT:
				// let the strap capture land before hold is looked at
				if (!bus.strap_sample &&
					(!eeprom_init_en || eeprom_done))
					next_state = bus.hold ? scs_pkg::ST_HALT : scs_pkg::ST_RUN;
			scs_pkg::ST_HALT:
				if (!bus.hold)
					next_state = scs_pkg::ST_RUN;
			default:
				next_state = state;
		endcase
		if (restart)
			next_state = scs_pkg::ST_ASSERT;
	end

	// ----------------------------------------------------------------
	// state, minimum reset width and event pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= scs_pkg::ST_ASSERT;
			cnt <= scs_pkg::MIN_RESET_CYC;
			bus.fund_start <= 1'b0;
			bus.strap_sample <= 1'b0;
			bus.core_rst_n <= 1'b0;
		end
		else
		begin
			state <= next_state;
			bus.fund_start <= restart && state != scs_pkg::ST_ASSERT;
			bus.strap_sample <= state == scs_pkg::ST_ASSERT &&
				next_state == scs_pkg::ST_INIT;
			bus.core_rst_n <= next_state == scs_pkg::ST_RUN;
			if (restart)
				cnt <= scs_pkg::MIN_RESET_CYC;
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
		end
	end

	assign bus.running = state == scs_pkg::ST_RUN;
	assign bus.eeprom_phase = state == scs_pkg::ST_INIT && eeprom_init_en;
endmodule

`default_nettype wire

// ==== src/scs_regs.sv ====
/*
 * Switch control and status registers of a three-port switch, with the
 * reset sequencing, lane reversal hand-off and reset-output pin control.
 * Assumes all inputs are synchronous to CLOCK; the GPIO block elsewhere
 * owns the pin whenever the alternate function is not selected.
 */

// What this block does
// - Status bits 21-23 mirror legacy B/C/D states.
// - Writing one to control bit 0 resets switch.
// - Reset trigger bit always reads zero.
// - Hold bit keeps core in reset; SMBus works.
// - Hold bit ignored once reset operation finished.
// - Hold bit set by pin or eeprom load.
// - Unlock bit gates writes to protected fields.
// - Unlock starts zero, set during reset operation.
// - Disable bit forces strong ordering of transactions.
// - Bits 4-6 reverse lanes of ports A-C.
// - Lane reversal bits start from strap pins.
// - Lane reversal applies at next link training.
// - External select: reset out follows external resets.
// - Internal select: reset out follows internal hot reset.
// - Internal select: fundamental reset tri-states the pin.

`timescale 1ns/1ps
`default_nettype none

module scs_regs
#(
	parameter int NUM_PORTS = 3
)
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic ARST_N,
	// reset sources
	input wire logic FUND_RST_N,
	input wire logic EXT_HOT_RST,
	input wire logic INT_HOT_RST,
	// straps and modes
	input wire logic HOLD_IN_RESET_PIN,
	input wire logic [NUM_PORTS-1:0] LANE_REV_STRAP,
	input wire logic NTB_MODE,
	input wire logic GPIO1_ALT_FUNC,
	input wire logic EEPROM_INIT_EN,
	input wire logic EEPROM_DONE,
	// register access from config, smbus or eeprom
	input wire logic REG_REQ,
	input wire logic REG_WR,
	input wire scs_pkg::scs_src_t REG_SRC,
	input wire logic [11:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic REG_ACK,
	// aggregated legacy interrupt states
	input wire logic LEGACY_IRQ_B_STATE,
	input wire logic LEGACY_IRQ_C_STATE,
	input wire logic LEGACY_IRQ_D_STATE,
	// transaction ordering
	input wire logic TLP_RO_ATTR,
	output logic TLP_RELAXED_OK,
	output logic RELAXED_ORDER_DISABLE,
	// link training
	input wire logic [NUM_PORTS-1:0] LINK_TRAIN_START,
	output logic [NUM_PORTS-1:0] PORT_LANE_REVERSAL,
	// core control
	output logic CORE_RST_N,
	output logic LOCK_PROTECT_RELEASE,
	// reset output on the gpio 1 alternate function
	output logic BRIDGE_RESET_OUT_N,
	output logic BRIDGE_RESET_OUT_OE
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	scs_seq_if seq_bus ();

	logic hold_in_reset;
	logic lock_protect_release;
	logic relaxed_order_disable;
	logic reset_output_source_select;
	logic [NUM_PORTS-1:0] lane_reversal;
	logic [NUM_PORTS-1:0] applied_reversal;
	logic legacy_irq_b_state;
	logic legacy_irq_c_state;
	logic legacy_irq_d_state;
	logic sw_reset;
	logic pin_float;
	logic src_ok;
	logic wr_ctl;
	logic rd_req;
	logic [31:0] ctl_view;
	logic [31:0] sts_view;
	logic next_reset_asserted;

	// ----------------------------------------------------------------
	// reset sequencer
	// ----------------------------------------------------------------
	scs_rst_seq u_seq
	(
		.clk(CLOCK),
		.arst_n(ARST_N),
		.fund_rst_n(FUND_RST_N),
		.eeprom_init_en(EEPROM_INIT_EN),
		.eeprom_done(EEPROM_DONE),
		.bus(seq_bus.seq)
	);

	assign seq_bus.sw_reset = sw_reset;
	assign seq_bus.hold = hold_in_reset;

	// ----------------------------------------------------------------
	// access qualification
	// ----------------------------------------------------------------
	// config writes need a running core; smbus works even while held,
	// eeprom writes only land during its load phase
	always_comb
	begin
		src_ok = 1'b0;
		if (REG_SRC == scs_pkg::SRC_SMBUS)
			src_ok = 1'b1;
		else if (REG_SRC == scs_pkg::SRC_EEPROM)
			src_ok = seq_bus.eeprom_phase;
		else if (REG_SRC == scs_pkg::SRC_CFG)
			src_ok = seq_bus.running;
	end

	assign wr_ctl = REG_REQ && REG_WR && src_ok &&
		REG_ADDR == scs_pkg::SWITCH_CONTROL_OFS;
	assign rd_req = REG_REQ && !REG_WR;

	// ----------------------------------------------------------------
	// software reset trigger
	// ----------------------------------------------------------------
	// only a one starts the reset; nothing is stored, so reads see zero
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
			sw_reset <= 1'b0;
		else
			sw_reset <= wr_ctl && REG_WDATA[scs_pkg::CTL_RESET_BIT];
	end

	// ----------------------------------------------------------------
	// hold in reset
	// ----------------------------------------------------------------
	// pin is captured as reset leaves its assert phase
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
			hold_in_reset <= scs_pkg::RST_VAL_HOLD;
		else if (seq_bus.fund_start)
			hold_in_reset <= scs_pkg::RST_VAL_HOLD;
		else if (seq_bus.strap_sample)
			hold_in_reset <= HOLD_IN_RESET_PIN;
		else if (wr_ctl)
			hold_in_reset <= REG_WDATA[scs_pkg::CTL_HOLD_BIT];
	end

	// ----------------------------------------------------------------
	// register unlock
	// ----------------------------------------------------------------
	// opened during every reset so the eeprom can load protected fields
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
			lock_protect_release <= scs_pkg::RST_VAL_UNLOCK;
		else if (seq_bus.fund_start)
			lock_protect_release <= scs_pkg::RST_VAL_UNLOCK;
		else if (seq_bus.strap_sample)
			lock_protect_release <= 1'b1;
		else if (wr_ctl)
			lock_protect_release <= REG_WDATA[scs_pkg::CTL_UNLOCK_BIT];
	end

	// other blocks gate their protected fields with this level
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
			LOCK_PROTECT_RELEASE <= scs_pkg::RST_VAL_UNLOCK;
		else
			LOCK_PROTECT_RELEASE <= lock_protect_release;
	end

	// ----------------------------------------------------------------
	// ordering and reset-output select
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			relaxed_order_disable <= scs_pkg::RST_VAL_RO_DIS;
			reset_output_source_select <= scs_pkg::RST_VAL_ROS;
		end
		else if (seq_bus.fund_start)
		begin
			relaxed_order_disable <= scs_pkg::RST_VAL_RO_DIS;
			reset_output_source_select <= scs_pkg::RST_VAL_ROS;
		end
		else if (wr_ctl)
		begin
			relaxed_order_disable <= REG_WDATA[scs_pkg::CTL_RO_DIS_BIT];
			reset_output_source_select <= REG_WDATA[scs_pkg::CTL_ROS_BIT];
		end
	end

	// relaxed attribute honoured only while ordering is not forced
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			TLP_RELAXED_OK <= 1'b0;
			RELAXED_ORDER_DISABLE <= scs_pkg::RST_VAL_RO_DIS;
		end
		else
		begin
			TLP_RELAXED_OK <= TLP_RO_ATTR && !relaxed_order_disable;
			RELAXED_ORDER_DISABLE <= relaxed_order_disable;
		end
	end

	// ----------------------------------------------------------------
	// lane reversal
	// ----------------------------------------------------------------
	// control value, loaded from straps as reset leaves assert phase
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
			lane_reversal <= '0;
		else if (seq_bus.strap_sample)
			lane_reversal <= LANE_REV_STRAP;
		else if (wr_ctl)
			lane_reversal <= REG_WDATA[scs_pkg::CTL_LREV_LSB +: NUM_PORTS];
	end

	// the lanes see a new value only when their port retrains,
	// so a write never flips lanes under a live link
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi = gi + 1)
		begin : g_port
			always_ff @(posedge CLOCK or negedge ARST_N)
			begin
				if (!ARST_N)
					applied_reversal[gi] <= 1'b0;
				else if (LINK_TRAIN_START[gi])
					applied_reversal[gi] <= lane_reversal[gi];
			end
		end
	endgenerate

	assign PORT_LANE_REVERSAL = applied_reversal;

	// ----------------------------------------------------------------
	// aggregated legacy interrupt states
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			legacy_irq_b_state <= 1'b0;
			legacy_irq_c_state <= 1'b0;
			legacy_irq_d_state <= 1'b0;
		end
		else
		begin
			legacy_irq_b_state <= LEGACY_IRQ_B_STATE;
			legacy_irq_c_state <= LEGACY_IRQ_C_STATE;
			legacy_irq_d_state <= LEGACY_IRQ_D_STATE;
		end
	end

	// ----------------------------------------------------------------
	// read views
	// ----------------------------------------------------------------
	// reserved and trigger bits are forced low here
	always_comb
	begin
		ctl_view = 32'h0000_0000;
		ctl_view[scs_pkg::CTL_HOLD_BIT] = hold_in_reset;
		ctl_view[scs_pkg::CTL_UNLOCK_BIT] = lock_protect_release;
		ctl_view[scs_pkg::CTL_RO_DIS_BIT] = relaxed_order_disable;
		ctl_view[scs_pkg::CTL_LREV_LSB +: NUM_PORTS] = lane_reversal;
		ctl_view[scs_pkg::CTL_ROS_BIT] = reset_output_source_select;
		sts_view = 32'h0000_0000;
		sts_view[scs_pkg::STS_IRQ_B_BIT] = legacy_irq_b_state;
		sts_view[scs_pkg::STS_IRQ_C_BIT] = legacy_irq_c_state;
		sts_view[scs_pkg::STS_IRQ_D_BIT] = legacy_irq_d_state;
	end

	// every request gets an ack next cycle, refused writes included
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			REG_RDATA <= scs_pkg::RST_VAL_RDATA;
			REG_ACK <= 1'b0;
		end
		else
		begin
			REG_ACK <= REG_REQ;
			if (rd_req && REG_ADDR == scs_pkg::SWITCH_STATUS_OFS)
				REG_RDATA <= sts_view;
			else if (rd_req && REG_ADDR == scs_pkg::SWITCH_CONTROL_OFS)
				REG_RDATA <= ctl_view;
			else if (REG_REQ)
				REG_RDATA <= scs_pkg::RST_VAL_RDATA;
		end
	end

	// ----------------------------------------------------------------
	// core reset
	// ----------------------------------------------------------------
	assign CORE_RST_N = seq_bus.core_rst_n;

	// ----------------------------------------------------------------
	// reset output pin
	// ----------------------------------------------------------------
	// a fundamental reset begun in internal mode floats the pin until
	// the core runs again; the select itself is cleared by that reset
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
			pin_float <= 1'b0;
		else if (seq_bus.fund_start)
			pin_float <= reset_output_source_select;
		else if (seq_bus.running)
			pin_float <= 1'b0;
	end

	always_comb
	begin
		if (reset_output_source_select)
			next_reset_asserted = INT_HOT_RST;
		else
			next_reset_asserted = EXT_HOT_RST || !FUND_RST_N;
	end

	// pin belongs to the gpio block unless ntb mode and alt function
	always_ff @(posedge CLOCK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			BRIDGE_RESET_OUT_N <= 1'b1;
			BRIDGE_RESET_OUT_OE <= 1'b0;
		end
		else
		begin
			BRIDGE_RESET_OUT_N <= !next_reset_asserted;
			BRIDGE_RESET_OUT_OE <= NTB_MODE && GPIO1_ALT_FUNC &&
				!pin_float;
		end
	end

endmodule

`default_nettype wire

// ==== sim/scs_regs_monitor.sv ====
/*
 * Concurrent checks on the ports of the switch control/status registers.
 * Assumes one clock domain and the port names of scs_regs.
 */

`timescale 1ns/1ps
`default_nettype none

module scs_regs_monitor
#(
	parameter int NUM_PORTS = 3
)
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic ARST_N,
	// reset sources and modes
	input wire logic FUND_RST_N,
	input wire logic EXT_HOT_RST,
	input wire logic INT_HOT_RST,
	input wire logic NTB_MODE,
	input wire logic GPIO1_ALT_FUNC,
	// register port
	input wire logic REG_REQ,
	input wire logic REG_WR,
	input wire scs_pkg::scs_src_t REG_SRC,
	input wire logic [11:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] REG_RDATA,
	input wire logic REG_ACK,
	// watched status and outputs
	input wire logic LEGACY_IRQ_B_STATE,
	input wire logic LEGACY_IRQ_C_STATE,
	input wire logic LEGACY_IRQ_D_STATE,
	input wire logic TLP_RO_ATTR,
	input wire logic TLP_RELAXED_OK,
	input wire logic RELAXED_ORDER_DISABLE,
	input wire logic [NUM_PORTS-1:0] LINK_TRAIN_START,
	input wire logic [NUM_PORTS-1:0] PORT_LANE_REVERSAL,
	input wire logic CORE_RST_N,
	input wire logic BRIDGE_RESET_OUT_N,
	input wire logic BRIDGE_RESET_OUT_OE
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// irq states packed in status bit order
	wire logic [2:0] irq = {LEGACY_IRQ_D_STATE, LEGACY_IRQ_C_STATE,
		LEGACY_IRQ_B_STATE};

	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);

	sequence s_rd(a);
		REG_REQ && !REG_WR && REG_ADDR == a;
	endsequence
	// eeprom writes are dropped while running, so only cfg or smbus
	sequence s_trig;
		REG_REQ && REG_WR && REG_ADDR == 12'h0a4 && REG_WDATA[0] &&
			CORE_RST_N && REG_SRC != scs_pkg::SRC_EEPROM;
	endsequence

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_ack; REG_REQ |=> REG_ACK; endproperty
	property p_no_ack; !REG_REQ |=> !REG_ACK; endproperty
	property p_trig_rd; s_rd(12'h0a4) |=> !REG_RDATA[0]; endproperty
	property p_ctl_rsvd;
		s_rd(12'h0a4) |=> REG_RDATA[31:9] == 23'h0 && !REG_RDATA[7];
	endproperty
	// status view lags the pins by one cycle, read data by one more
	property p_sts;
		s_rd(12'h0a0) |=> REG_RDATA == {8'h00, $past(irq, 2), 21'h0};
	endproperty
	property p_relax;
		$past(ARST_N) |-> TLP_RELAXED_OK ==
			($past(TLP_RO_ATTR) && !RELAXED_ORDER_DISABLE);
	endproperty
	property p_lane;
		LINK_TRAIN_START == '0 |=> $stable(PORT_LANE_REVERSAL);
	endproperty
	property p_oe;
		!$past(NTB_MODE && GPIO1_ALT_FUNC) |-> !BRIDGE_RESET_OUT_OE;
	endproperty
	property p_out_idle;
		BRIDGE_RESET_OUT_OE &&
			!$past(EXT_HOT_RST || INT_HOT_RST || !FUND_RST_N)
			|-> BRIDGE_RESET_OUT_N;
	endproperty
	property p_fund; !FUND_RST_N |-> ##[1:2] !CORE_RST_N; endproperty
	property p_sw_rst; s_trig |-> ##[1:2] !CORE_RST_N; endproperty

	a_ack: assert property (p_ack) else $error("no ack after request");
	a_no_ack: assert property (p_no_ack) else $error("stray ack");
	a_trig_rd: assert property (p_trig_rd)
		else $error("reset trigger bit read as one");
	a_ctl_rsvd: assert property (p_ctl_rsvd)
		else $error("reserved control bits not zero");
	a_sts: assert property (p_sts)
		else $error("status read does not match irq states");
	a_relax: assert property (p_relax)
		else $error("relaxed ordering result wrong");
	a_lane: assert property (p_lane)
		else $error("lane reversal changed without training");
	a_oe: assert property (p_oe)
		else $error("reset pin driven outside its mode");
	a_out_idle: assert property (p_out_idle)
		else $error("reset pin asserted with no cause");
	a_fund: assert property (p_fund)
		else $error("core not held during fundamental reset");
	a_sw_rst: assert property (p_sw_rst)
		else $error("software trigger did not reset core");
endmodule

bind scs_regs scs_regs_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (.*);

`default_nettype wire

// ==== sim/scs_regs_tb.sv ====
/*
 * Self-checking bench for scs_regs, one task per scenario.
 * Assumes the bound checker and a 25 MHz clock.
 */

`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
	n_mismatch++; $display("[FAIL] t=%0t got %h exp %h", $time, a, e); \
	end end

module scs_regs_tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clock, arst_n, fund_n, ext, inth, hold_pin, ntb, alt, ee_en;
	logic ee_done, req, wr, ro, irq_b, irq_c, irq_d, ack, ro_ok, ro_dis;
	logic core_n, lock, out_n, oe;
	logic [2:0] strap, train, lanes;
	logic [11:0] addr;
	logic [31:0] wdata, rdata;
	scs_pkg::scs_src_t src;
	int n_mismatch, check_count, cyc;

	scs_regs i_dut (.CLOCK(clock), .ARST_N(arst_n), .FUND_RST_N(fund_n),
		.EXT_HOT_RST(ext), .INT_HOT_RST(inth), .HOLD_IN_RESET_PIN(hold_pin),
		.LANE_REV_STRAP(strap), .NTB_MODE(ntb), .GPIO1_ALT_FUNC(alt),
		.EEPROM_INIT_EN(ee_en), .EEPROM_DONE(ee_done), .REG_REQ(req),
		.REG_WR(wr), .REG_SRC(src), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .REG_ACK(ack), .LEGACY_IRQ_B_STATE(irq_b),
		.LEGACY_IRQ_C_STATE(irq_c), .LEGACY_IRQ_D_STATE(irq_d),
		.TLP_RO_ATTR(ro), .TLP_RELAXED_OK(ro_ok),
		.RELAXED_ORDER_DISABLE(ro_dis), .LINK_TRAIN_START(train),
		.PORT_LANE_REVERSAL(lanes), .CORE_RST_N(core_n),
		.LOCK_PROTECT_RELEASE(lock), .BRIDGE_RESET_OUT_N(out_n),
		.BRIDGE_RESET_OUT_OE(oe));

	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// whole run is well under a thousand cycles
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic nc(input int n);
		repeat (n) @(negedge clock);
	endtask
	// one access: request for one edge; ack stands one cycle only,
	// so ack and data are judged at the very next negedge
	task automatic acc(input scs_pkg::scs_src_t s, input logic w,
		input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
		src = s;
		wr = w;
		addr = a;
		wdata = d;
		req = 1'b1;
		nc(1);
		`CHK(ack, 1'b1)
		if (!w)
			`CHK(rdata, e)
		req = 1'b0;
		nc(1);
	endtask
	task automatic wait_run();
		int i;
		i = 0;
		while (core_n !== 1'b1 && i < 200)
		begin
			nc(1);
			i++;
		end
		`CHK(core_n, 1'b1)
	endtask
	task automatic fund_pulse();
		fund_n = 1'b0;
		nc(2);
		fund_n = 1'b1;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_vals();
		acc(scs_pkg::SRC_CFG, 0, 12'h0a4, 0, 32'h54);
		`CHK(lock, 1'b1)
		$display("reset values done");
	endtask
	task automatic t_status();
		irq_b = 1;
		irq_d = 1;
		nc(3);
		acc(scs_pkg::SRC_CFG, 0, 12'h0a0, 0, 32'h00a0_0000);
		{irq_b, irq_c, irq_d} = 3'b010;
		nc(3);
		acc(scs_pkg::SRC_CFG, 0, 12'h0a0, 0, 32'h0040_0000);
		$display("status done");
	endtask
	task automatic t_ctl_write();
		ro = 1;
		acc(scs_pkg::SRC_CFG, 1, 12'h0a4, 32'hffff_fe88, 0);
		acc(scs_pkg::SRC_CFG, 0, 12'h0a4, 0, 32'h08);
		nc(1);
		`CHK({ro_dis, ro_ok, lock, core_n}, 4'b1001)
		acc(scs_pkg::SRC_CFG, 1, 12'h0a4, 32'h04, 0);
		nc(2);
		`CHK({ro_dis, ro_ok, lock}, 3'b011)
		$display("control write done");
	endtask
	task automatic t_lane();
		acc(scs_pkg::SRC_CFG, 1, 12'h0a4, 32'h24, 0);
		acc(scs_pkg::SRC_CFG, 0, 12'h0a4, 0, 32'h24);
		nc(2);
		`CHK(lanes, 3'b000)
		train = 3'b111;
		nc(1);
		train = 3'b000;
		nc(1);
		`CHK(lanes, 3'b010)
		acc(scs_pkg::SRC_CFG, 0, 12'h0b0, 0, 0);
		$display("lane reversal done");
	endtask
	task automatic t_rst_out();
		ntb = 1;
		alt = 1;
		ext = 1;
		nc(2);
		`CHK({oe, out_n}, 2'b10)
		ext = 0;
		inth = 1;
		nc(2);
		`CHK({oe, out_n}, 2'b11)
		acc(scs_pkg::SRC_CFG, 1, 12'h0a4, 32'h124, 0);
		nc(1);
		`CHK(out_n, 1'b0)
		ext = 1;
		inth = 0;
		nc(2);
		`CHK(out_n, 1'b1)
		ext = 0;
		$display("reset output done");
	endtask
	task automatic t_sw_reset();
		acc(scs_pkg::SRC_CFG, 1, 12'h0a4, 32'h125, 0);
		nc(3);
		`CHK({core_n, oe}, 2'b00)
		nc(10);
		`CHK(oe, 1'b0)
		wait_run();
		acc(scs_pkg::SRC_SMBUS, 0, 12'h0a4, 0, 32'h54);
		nc(2);
		`CHK(oe, 1'b1)
		$display("software reset done");
	endtask
	task automatic t_hold();
		hold_pin = 1;
		fund_pulse();
		nc(60);
		`CHK(core_n, 1'b0)
		acc(scs_pkg::SRC_SMBUS, 0, 12'h0a4, 0, 32'h56);
		hold_pin = 0;
		acc(scs_pkg::SRC_SMBUS, 1, 12'h0a4, 32'h54, 0);
		wait_run();
		acc(scs_pkg::SRC_CFG, 1, 12'h0a4, 32'h56, 0);
		nc(8);
		`CHK(core_n, 1'b1)
		acc(scs_pkg::SRC_CFG, 1, 12'h0a4, 32'h54, 0);
		$display("hold done");
	endtask
	task automatic t_eeprom();
		ee_en = 1;
		fund_pulse();
		nc(35);
		acc(scs_pkg::SRC_EEPROM, 1, 12'h0a4, 32'h56, 0);
		ee_done = 1;
		nc(1);
		ee_done = 0;
		nc(10);
		`CHK(core_n, 1'b0)
		acc(scs_pkg::SRC_SMBUS, 0, 12'h0a4, 0, 32'h56);
		acc(scs_pkg::SRC_SMBUS, 1, 12'h0a4, 32'h54, 0);
		ee_en = 0;
		wait_run();
		$display("eeprom load done");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		{arst_n, ext, inth, hold_pin, ntb, alt, ee_en, ee_done} = 8'h00;
		{req, wr, ro, irq_b, irq_c, irq_d, cyc} = 0;
		{n_mismatch, check_count, train, addr, wdata} = 0;
		fund_n = 1;
		strap = 3'b101;
		src = scs_pkg::SRC_CFG;
		repeat (4) @(posedge clock);
		@(negedge clock);
		`CHK(lock, 1'b0)
		arst_n = 1;
		wait_run();
		t_reset_vals();
		t_status();
		t_ctl_write();
		t_lane();
		t_rst_out();
		t_sw_reset();
		t_hold();
		t_eeprom();
		give_verdict();
	end
endmodule

`default_nettype wire
